// ### design/dmh_fifo.sv
/*
 Small FIFO with valid/ready on both sides and a registered output stage.
 Assumes one clock; i_clr flushes every entry in one cycle.
*/
`timescale 1ns/1ns
module dmh_fifo import dmh_pkg::*; #(
    parameter int WIDTH = 9,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_clr,
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
            $error("dmh_fifo: DEPTH must be a power of two, 2 or more");
        end
    endgenerate

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic rdy_r, rdy_nxt, ov_r, ov_nxt;
    logic [WIDTH-1:0] od_r, od_nxt;
    logic push, pop;

    always_comb begin
        push = i_in_valid && rdy_r;
        pop = (cnt_r != '0) && (!ov_r || i_out_ready);
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        ov_nxt = pop || (ov_r && !i_out_ready);
        od_nxt = pop ? mem_r[rp_r] : od_r;
        if (i_clr) begin
            wp_nxt = '0;
            rp_nxt = '0;
            cnt_nxt = '0;
            ov_nxt = 1'b0;
        end
        // Ready is registered, so it is judged from the next count
        rdy_nxt = cnt_nxt != (AW+1)'(DEPTH);
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b0;
            ov_r <= 1'b0;
            od_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
            ov_r <= ov_nxt;
            od_r <= od_nxt;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem_r[wp_r] <= i_in_data;
        end
    end

    assign o_in_ready = rdy_r;
    assign o_out_valid = ov_r;
    assign o_out_data = od_r;
endmodule : dmh_fifo

// ### design/dmh_host_port.sv
/*
 Host port of the display module: parallel (two bus styles) or serial
 link, bytes tagged data/command into a FIFO, read bytes driven back.
 Assumes every pin is asynchronous and sampled by i_sys_clk; host
 strobe phases must last several system clocks.
*/
`timescale 1ns/1ns
module dmh_host_port import dmh_pkg::*; #(
    parameter int DW = DATA_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic i_bus_style_select,
    input wire logic i_link_type_select,
    input wire logic i_cs_n,
    input wire logic i_reset_n,
    input wire logic i_dc,
    input wire logic i_wr_n_rw,
    input wire logic i_rd_n_en,
    input wire logic [DW-1:0] i_data,
    output logic [DW-1:0] o_data,
    output logic [DW-1:0] o_data_oe,
    input wire logic i_panel_power_ctl,
    output logic o_panel_power_on,
    output logic o_init_active,
    output logic o_rx_valid,
    output logic [DW-1:0] o_rx_data,
    output logic o_rx_is_data,
    input wire logic i_rx_ready,
    input wire logic [DW-1:0] i_rd_data,
    output logic o_rd_req,
    output logic o_overrun
);
    generate
        if (DW != 8) begin : g_bad_dw
            $error("dmh_host_port: the host bus is 8 bits wide");
        end
    endgenerate

    localparam int NS = DW + 8;
    logic [NS-1:0] pins_s;
    logic style_s, link_s, cs_n_s, rstpin_s, dc_s, wr_s, rd_s, pwr_s;
    logic [DW-1:0] d_s;

    dmh_sync #(.W(NS)) u_sync (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_async({i_bus_style_select, i_link_type_select, i_cs_n,
                  i_reset_n, i_dc, i_wr_n_rw, i_rd_n_en,
                  i_panel_power_ctl, i_data}),
        .o_sync(pins_s)
    );
    assign {style_s, link_s, cs_n_s, rstpin_s, dc_s, wr_s, rd_s, pwr_s,
            d_s} = pins_s;

    dmh_state_t state_r, state_nxt;
    logic style_r, style_nxt, link_r, link_nxt;
    logic wr_q_r, wr_q_nxt, rd_q_r, rd_q_nxt, scl_q_r, scl_q_nxt;
    logic pend_r, pend_nxt, pend_dc_r, pend_dc_nxt;
    logic [DW-1:0] pend_byte_r, pend_byte_nxt;
    logic [DW-1:0] sh_r, sh_nxt;
    logic [3:0] bit_cnt_r, bit_cnt_nxt;
    logic sdir_r, sdir_nxt;
    logic [DW-1:0] oe_r, oe_nxt, dout_r, dout_nxt;
    logic rd_req_r, rd_req_nxt, pwr_r, pwr_nxt;
    logic ovr_r, ovr_nxt, init_r, init_nxt;
    logic fifo_ready, fifo_clr;
    logic cs_act, scl_rise, scl_fall, cap;
    logic [DW-1:0] cap_byte;
    logic [DW:0] fifo_out;

    dmh_fifo #(.WIDTH(DW + 1), .DEPTH(DEPTH)) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_nrst(i_nrst),
        .i_clr(fifo_clr),
        .i_in_valid(pend_r),
        .i_in_data({pend_dc_r, pend_byte_r}),
        .o_in_ready(fifo_ready),
        .o_out_valid(o_rx_valid),
        .o_out_data(fifo_out),
        .i_out_ready(i_rx_ready)
    );
    assign o_rx_is_data = fifo_out[DW];
    assign o_rx_data = fifo_out[DW-1:0];
    assign fifo_clr = !rstpin_s; // R4

    always_comb begin
        state_nxt = state_r;
        style_nxt = style_r;
        link_nxt = link_r;
        wr_q_nxt = wr_s;
        rd_q_nxt = rd_s;
        scl_q_nxt = d_s[SER_CLK_BIT];
        sh_nxt = sh_r;
        bit_cnt_nxt = bit_cnt_r;
        sdir_nxt = sdir_r;
        oe_nxt = oe_r;
        dout_nxt = dout_r;
        rd_req_nxt = 1'b0;
        pwr_nxt = pwr_s; // R13
        ovr_nxt = ovr_r;
        init_nxt = !rstpin_s;
        cap = 1'b0;
        cap_byte = d_s;
        cs_act = !cs_n_s; // R3
        // Edge memories reset low; the synced reset pin hides that edge
        scl_rise = d_s[SER_CLK_BIT] && !scl_q_r;
        scl_fall = !d_s[SER_CLK_BIT] && scl_q_r;
        if (!cs_act) begin
            // Straps are taken only between transfers so a strap that
            // moves mid-transfer cannot split a byte
            style_nxt = style_s; // R1
            link_nxt = link_s; // R2
            state_nxt = DMH_IDLE; // R14
            bit_cnt_nxt = BIT_ZERO; // R14
            oe_nxt = OE_NONE; // R14
        end else if (link_r == LINK_PARALLEL) begin
            unique case (state_r)
                DMH_IDLE: begin
                    if (style_r == STYLE_SEP) begin
                        if (!rd_s) begin
                            state_nxt = DMH_RD; // R8
                        end else if (wr_s && !wr_q_r) begin
                            cap = 1'b1; // R6
                        end
                    end else if (rd_s && !rd_q_r) begin
                        state_nxt = wr_s ? DMH_RD : DMH_WR; // R7 R9
                    end
                end
                DMH_WR: begin
                    if (!rd_s) begin
                        cap = 1'b1; // R7
                        state_nxt = DMH_IDLE;
                    end
                end
                DMH_RD: begin
                    if ((style_r == STYLE_SEP) == rd_s) begin
                        state_nxt = DMH_IDLE;
                        rd_req_nxt = 1'b1;
                    end
                end
                default: state_nxt = DMH_IDLE;
            endcase
            oe_nxt = (state_nxt == DMH_RD) ? OE_ALL : OE_NONE; // R10
            dout_nxt = i_rd_data;
        end else begin
            if (bit_cnt_r == BIT_ZERO) begin
                sdir_nxt = d_s[SER_DIR_BIT]; // R12
                sh_nxt = i_rd_data;
                dout_nxt = OE_NONE;
                dout_nxt[SER_OUT_BIT] = i_rd_data[DW-1];
            end
            if (scl_rise) begin
                bit_cnt_nxt = (bit_cnt_r == BIT_LAST) ? BIT_ZERO :
                              bit_cnt_r + BIT_ONE;
                if (sdir_nxt == DIR_WRITE) begin
                    sh_nxt = {sh_r[DW-2:0], d_s[SER_IN_BIT]}; // R11
                    if (bit_cnt_r == BIT_LAST) begin
                        cap = 1'b1;
                        cap_byte = {sh_r[DW-2:0], d_s[SER_IN_BIT]};
                    end
                end else if (bit_cnt_r == BIT_LAST) begin
                    rd_req_nxt = 1'b1;
                end
            end else if (scl_fall && bit_cnt_r != BIT_ZERO &&
                         sdir_r == DIR_READ) begin
                sh_nxt = {sh_r[DW-2:0], 1'b0};
                dout_nxt[SER_OUT_BIT] = sh_r[DW-2]; // R11
            end
            oe_nxt = (sdir_nxt == DIR_READ) ? OE_SER : OE_NONE; // R12
        end
        pend_nxt = pend_r && !fifo_ready;
        pend_dc_nxt = pend_dc_r;
        pend_byte_nxt = pend_byte_r;
        if (cap) begin
            // A byte is only lost if the previous one is still stuck
            if (pend_r && !fifo_ready) begin
                ovr_nxt = 1'b1;
            end else begin
                pend_nxt = 1'b1;
                pend_dc_nxt = dc_s; // R5
                pend_byte_nxt = cap_byte; // R5
            end
        end
        if (!rstpin_s) begin
            state_nxt = DMH_IDLE; // R4
            bit_cnt_nxt = BIT_ZERO; // R4
            pend_nxt = 1'b0; // R4
            oe_nxt = OE_NONE; // R4
            ovr_nxt = 1'b0; // R4
            rd_req_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_r <= DMH_IDLE;
            style_r <= STYLE_SEP;
            link_r <= LINK_SERIAL;
            wr_q_r <= 1'b0;
            rd_q_r <= 1'b0;
            scl_q_r <= 1'b0;
            pend_r <= 1'b0;
            pend_dc_r <= DC_CMD;
            pend_byte_r <= '0;
            sh_r <= '0;
            bit_cnt_r <= BIT_ZERO;
            sdir_r <= DIR_WRITE;
            oe_r <= OE_NONE;
            dout_r <= '0;
            rd_req_r <= 1'b0;
            pwr_r <= 1'b0;
            ovr_r <= 1'b0;
            init_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            style_r <= style_nxt;
            link_r <= link_nxt;
            wr_q_r <= wr_q_nxt;
            rd_q_r <= rd_q_nxt;
            scl_q_r <= scl_q_nxt;
            pend_r <= pend_nxt;
            pend_dc_r <= pend_dc_nxt;
            pend_byte_r <= pend_byte_nxt;
            sh_r <= sh_nxt;
            bit_cnt_r <= bit_cnt_nxt;
            sdir_r <= sdir_nxt;
            oe_r <= oe_nxt;
            dout_r <= dout_nxt;
            rd_req_r <= rd_req_nxt;
            pwr_r <= pwr_nxt;
            ovr_r <= ovr_nxt;
            init_r <= init_nxt;
        end
    end

    assign o_data = dout_r;
    assign o_data_oe = oe_r;
    assign o_rd_req = rd_req_r;
    assign o_panel_power_on = pwr_r;
    assign o_overrun = ovr_r;
    assign o_init_active = init_r;

    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);

    chk_idle_float: assert property ( // R14
        cs_n_s |=> o_data_oe == OE_NONE && state_r == DMH_IDLE)
        else $error("outputs driven while chip select high");
    chk_power_follow: assert property ( // R13
        pwr_s != $past(pwr_s) |=> o_panel_power_on == $past(pwr_s))
        else $error("panel power does not follow its input");
    chk_init_clear: assert property ( // R4
        !rstpin_s |=> !pend_r && bit_cnt_r == BIT_ZERO && o_init_active)
        else $error("reset pin did not clear transfer state");
    chk_sep_write: assert property ( // R6
        rstpin_s && cs_act && link_r == LINK_PARALLEL &&
        style_r == STYLE_SEP && state_r == DMH_IDLE && rd_s &&
        $rose(wr_s) && !pend_r |=> pend_r && pend_byte_r == $past(d_s)
        && pend_dc_r == $past(dc_s))
        else $error("write strobe byte or qualifier not captured");
    chk_sep_read: assert property ( // R8
        rstpin_s && cs_act && link_r == LINK_PARALLEL &&
        style_r == STYLE_SEP && !rd_s |=> o_data_oe == OE_ALL)
        else $error("read strobe did not drive the bus");
    chk_ena_dir: assert property ( // R7
        rstpin_s && cs_act && link_r == LINK_PARALLEL &&
        style_r == STYLE_ENA && state_r == DMH_IDLE && $rose(rd_s)
        |=> state_r == ($past(wr_s) ? DMH_RD : DMH_WR))
        else $error("enable style direction decoded wrongly");
    chk_ena_start: assert property ( // R9
        link_r == LINK_PARALLEL && style_r == STYLE_ENA &&
        state_r == DMH_IDLE && !(rd_s && !rd_q_r) |=> state_r == DMH_IDLE)
        else $error("transfer started without enable rising");
    chk_par_release: assert property ( // R10
        rstpin_s && cs_act && state_r == DMH_RD ##1
        state_r == DMH_IDLE |-> o_rd_req
        ##1 o_data_oe == OE_NONE || !rstpin_s)
        else $error("read end did not release bus and pulse");
    chk_ser_drive: assert property ( // R12
        rstpin_s && cs_act && link_r == LINK_SERIAL &&
        bit_cnt_r == BIT_ZERO |=> o_data_oe ==
        ($past(d_s[SER_DIR_BIT]) ? OE_SER : OE_NONE))
        else $error("serial direction did not set the data driver");
    chk_ser_byte: assert property ( // R11
        rstpin_s && cs_act && link_r == LINK_SERIAL && scl_rise &&
        sdir_nxt == DIR_WRITE && bit_cnt_r == BIT_LAST && !pend_r
        |=> pend_r && pend_byte_r[0] == $past(d_s[SER_IN_BIT]))
        else $error("serial byte not completed on eighth edge");
    chk_strap_latch: assert property ( // R1 R2
        cs_n_s |=> style_r == $past(style_s) && link_r == $past(link_s))
        else $error("straps not taken while chip select high");
    chk_cs_gate: assert property ( // R3
        cs_n_s && !pend_r |=> !pend_r)
        else $error("byte taken while chip select high");
    chk_par_drive: assert property ( // R10
        link_r == LINK_PARALLEL |->
        (o_data_oe == OE_ALL) == (state_r == DMH_RD))
        else $error("parallel bus driven outside a host read");
    chk_ena_write: assert property ( // R5 R7
        rstpin_s && cs_act && link_r == LINK_PARALLEL &&
        state_r == DMH_WR && !rd_s && !pend_r |=> pend_r &&
        pend_byte_r == $past(d_s) && pend_dc_r == $past(dc_s))
        else $error("enable style write byte not captured");
    chk_ser_read_end: assert property ( // R12
        rstpin_s && cs_act && link_r == LINK_SERIAL && scl_rise &&
        sdir_nxt == DIR_READ && bit_cnt_r == BIT_LAST |=> o_rd_req)
        else $error("serial read end did not pulse the read request");
endmodule : dmh_host_port

// ### design/dmh_pkg.sv
/*
 Constants, states and timing figures of the display module host port.
 Assumes a single system clock; all pins arrive asynchronous to it.
*/
// Summary of operation
// R1: Bus-style strap low: separate strobes; high: enable
// R2: Link strap low: serial; high: 8-bit parallel
// R3: Host talks only while chip select low
// R4: Reset pin low initialises all transfer logic
// R5: Qualifier high marks display data, low command
// R6: Separate-strobe style: shared pin is write strobe
// R7: Enable style: shared pin high reads, low writes
// R8: Separate-strobe style: other pin is read strobe
// R9: Enable style: transfer starts on enable high
// R10: Parallel: drive bus only during host reads
// R11: Serial: line0 clock, line1 in, line2 out
// R12: Serial: line3 high reads, low writes
// R13: Panel supply follows the panel power input
// R14: Chip select high: ignore strobes, float outputs
package dmh_pkg;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 8;
    localparam int SYS_CLK_NS = 4;
    localparam int LINK_CLK_NS = 48;
    localparam int SER_CLK_BIT = 0;
    localparam int SER_IN_BIT = 1;
    localparam int SER_OUT_BIT = 2;
    localparam int SER_DIR_BIT = 3;
    localparam logic STYLE_SEP = 1'b0;
    localparam logic STYLE_ENA = 1'b1;
    localparam logic LINK_SERIAL = 1'b0;
    localparam logic LINK_PARALLEL = 1'b1;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic DC_CMD = 1'b0;
    localparam logic DC_DATA = 1'b1;
    localparam logic [7:0] OE_NONE = 8'h00;
    localparam logic [7:0] OE_ALL = 8'hff;
    localparam logic [7:0] OE_SER = 8'h04;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE = 4'h1;

    // Idle, then write or read; each leaves back to idle
    typedef enum logic [1:0] {
        DMH_IDLE = 2'b00,
        DMH_WR = 2'b01,
        DMH_RD = 2'b10
    } dmh_state_t;
endpackage : dmh_pkg

// ### design/dmh_sync.sv
/*
 Two-flop synchroniser for a vector of independent pin levels.
 Assumes each bit is a level; multi-bit words are not coherent.
*/
`timescale 1ns/1ns
module dmh_sync import dmh_pkg::*; #(
    parameter int W = 1
) (
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    generate
        if (W < 1) begin : g_bad_w
            $error("dmh_sync: W must be at least 1");
        end
    endgenerate

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            meta_r <= '0;
            sync_r <= '0;
        end else begin
            meta_r <= i_async;
            sync_r <= meta_r;
        end
    end

    assign o_sync = sync_r;
endmodule : dmh_sync

// ### verification/display_module_host_interface_tb.sv
/*
 Self-checking bench of the host port: both bus styles, serial link,
 chip select, reset pin, panel power and FIFO overrun.
 Assumes dmh_host_model stands in for the host and the bench consumes.
*/
`timescale 1ns/1ns
module display_module_host_interface_tb import dmh_pkg::*;;
    logic i_sys_clk, i_nrst, style, link, reset_n, pwr, rx_ready;
    logic [7:0] rd_data;
    logic cs_n, dc, wr, rd, pwr_on, init, rx_valid, rx_dc, rd_req, ovr;
    logic [7:0] bus, o_data, o_oe, rx_data, seen, soe;
    logic oe2;
    int fail_count = 0;
    int n_compared = 0;
    int rd_pulses = 0;
    int n;
    always #(SYS_CLK_NS / 2) i_sys_clk = ~i_sys_clk;
    always @(posedge i_sys_clk) begin
        if (rd_req === 1'b1) begin
            rd_pulses <= rd_pulses + 1;
        end
    end
    dmh_host_port dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
        .i_bus_style_select(style), .i_link_type_select(link),
        .i_cs_n(cs_n), .i_reset_n(reset_n), .i_dc(dc), .i_wr_n_rw(wr),
        .i_rd_n_en(rd), .i_data(bus), .o_data(o_data), .o_data_oe(o_oe),
        .i_panel_power_ctl(pwr), .o_panel_power_on(pwr_on),
        .o_init_active(init), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .o_rx_is_data(rx_dc), .i_rx_ready(rx_ready), .i_rd_data(rd_data),
        .o_rd_req(rd_req), .o_overrun(ovr));
    dmh_host_model host (.i_sys_clk(i_sys_clk), .i_dut_data(o_data),
        .i_dut_oe(o_oe), .o_cs_n(cs_n), .o_dc(dc), .o_wr_n_rw(wr),
        .o_rd_n_en(rd), .o_bus(bus));
    task check(input logic [7:0] s, e);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check
    task print_verdict();
        if (fail_count == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    task pop(input logic [7:0] b, input logic d);
        host.step(1);
        for (int k = 0; k < 60 && rx_valid !== 1'b1; k++) host.step(1);
        check({7'h0, rx_valid}, 8'h01);
        check(rx_data, b);
        check({7'h0, rx_dc}, {7'h0, d});
        rx_ready = 1'b1;
        host.step(1);
        rx_ready = 1'b0;
    endtask : pop
    task t_power();
        pwr = 1'b1;
        host.step(4);
        check({7'h0, pwr_on}, 8'h01);
        pwr = 1'b0;
        host.step(4);
        check({7'h0, pwr_on}, 8'h00);
    endtask : t_power
    task t_write(input logic st, input logic [7:0] a, b);
        host.par_wr(st, 1'b0, DC_DATA, a);
        host.par_wr(st, 1'b0, DC_CMD, b);
        pop(a, DC_DATA);
        pop(b, DC_CMD);
    endtask : t_write
    task t_read(input logic st, input logic [7:0] b);
        rd_data = b;
        n = rd_pulses;
        host.par_rd(st, 1'b0, seen, soe);
        check(soe, 8'hff);
        check(seen, b);
        check(8'(rd_pulses - n), 8'h01);
        check(o_oe, 8'h00);
    endtask : t_read
    // Strobes with chip select high must leave no trace at all
    task t_cs_high(input logic st);
        n = rd_pulses;
        host.par_wr(st, 1'b1, DC_DATA, 8'h77);
        host.step(8);
        check({7'h0, rx_valid}, 8'h00);
        host.par_rd(st, 1'b1, seen, soe);
        check(soe, 8'h00);
        check(8'(rd_pulses - n), 8'h00);
    endtask : t_cs_high
    task t_serial();
        link = LINK_SERIAL;
        host.step(4);
        host.ser_xfer(DIR_WRITE, DC_DATA, 8'hb4, seen, oe2);
        pop(8'hb4, DC_DATA);
        rd_data = 8'hc3;
        n = rd_pulses;
        host.ser_xfer(DIR_READ, DC_CMD, 8'h00, seen, oe2);
        check(seen, 8'hc3);
        check({7'h0, oe2}, 8'h01);
        check(8'(rd_pulses - n), 8'h01);
        check({7'h0, rx_valid}, 8'h00);
        link = LINK_PARALLEL;
        host.step(4);
    endtask : t_serial
    // Consumer stalls until the FIFO refuses; the reset pin flushes it
    task t_overrun();
        logic [7:0] b;
        check({7'h0, ovr}, 8'h00);
        for (b = 8'h10; b < 8'h1c; b++) begin
            host.par_wr(STYLE_SEP, 1'b0, DC_DATA, b);
        end
        check({7'h0, ovr}, 8'h01);
        for (b = 8'h10; b < 8'h18; b++) pop(b, DC_DATA);
        reset_n = 1'b0;
        host.step(4);
        check({7'h0, init}, 8'h01);
        reset_n = 1'b1;
        host.step(4);
        check({7'h0, rx_valid}, 8'h00);
        check({7'h0, ovr}, 8'h00);
        check({7'h0, init}, 8'h00);
    endtask : t_overrun
    initial begin
        #100000;
        fail_count++;
        print_verdict();
    end
    initial begin
        i_sys_clk = 1'b0;
        i_nrst = 1'b0;
        style = STYLE_SEP;
        link = LINK_PARALLEL;
        reset_n = 1'b0;
        pwr = 1'b0;
        rx_ready = 1'b0;
        rd_data = 8'h00;
        host.step(16);
        check(o_oe, 8'h00);
        check({6'h0, init, pwr_on}, 8'h02);
        i_nrst = 1'b1;
        host.step(4);
        check({7'h0, init}, 8'h01);
        reset_n = 1'b1;
        host.step(4);
        check({7'h0, init}, 8'h00);
        t_power();
        t_write(STYLE_SEP, 8'ha5, 8'h3c);
        t_read(STYLE_SEP, 8'h5a);
        t_cs_high(STYLE_SEP);
        host.set_idle(STYLE_ENA);
        style = STYLE_ENA;
        host.step(4);
        t_write(STYLE_ENA, 8'hc6, 8'h19);
        t_read(STYLE_ENA, 8'h96);
        t_cs_high(STYLE_ENA);
        style = STYLE_SEP;
        host.set_idle(STYLE_SEP);
        host.step(4);
        t_serial();
        t_overrun();
        print_verdict();
    end
endmodule : display_module_host_interface_tb

// ### verification/dmh_host_model.sv
/*
 Host model: chip select, qualifier, strobes and the shared data pins.
 Assumes the bench calls its tasks; the bus is resolved here from the
 port's drive enables and the host's own.
*/
`timescale 1ns/1ns
module dmh_host_model import dmh_pkg::*; (
    input wire logic i_sys_clk,
    input wire logic [7:0] i_dut_data,
    input wire logic [7:0] i_dut_oe,
    output logic o_cs_n,
    output logic o_dc,
    output logic o_wr_n_rw,
    output logic o_rd_n_en,
    output logic [7:0] o_bus
);
    logic [7:0] drv;
    logic [7:0] host_oe;
    // Released bits show the inverse, so a stale byte never passes
    assign o_bus = (i_dut_oe & i_dut_data) | (~i_dut_oe & host_oe & drv)
        | (~i_dut_oe & ~host_oe & ~drv);
    initial begin
        drv = 8'h00;
        host_oe = 8'hff;
        o_cs_n = 1'b1;
        o_dc = 1'b0;
        o_wr_n_rw = 1'b1;
        o_rd_n_en = 1'b1;
    end
    task step(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : step
    // Separate style idles both strobes high, enable style E low, write
    task set_idle(input logic style);
        o_wr_n_rw = (style == STYLE_SEP);
        o_rd_n_en = (style == STYLE_SEP);
    endtask : set_idle
    task par_wr(input logic style, cs, dc, input logic [7:0] b);
        o_cs_n = cs;
        o_dc = dc;
        drv = b;
        host_oe = 8'hff;
        step(2);
        if (style == STYLE_SEP) o_wr_n_rw = 1'b0;
        else o_rd_n_en = 1'b1;
        step(6);
        if (style == STYLE_SEP) o_wr_n_rw = 1'b1;
        else o_rd_n_en = 1'b0;
        step(6);
        o_cs_n = 1'b1;
        step(2);
    endtask : par_wr
    task par_rd(input logic style, cs, output logic [7:0] seen, soe);
        o_cs_n = cs;
        host_oe = 8'h00;
        if (style == STYLE_ENA) o_wr_n_rw = 1'b1;
        step(2);
        if (style == STYLE_SEP) o_rd_n_en = 1'b0;
        else o_rd_n_en = 1'b1;
        step(6);
        seen = o_bus;
        soe = i_dut_oe;
        if (style == STYLE_SEP) o_rd_n_en = 1'b1;
        else o_rd_n_en = 1'b0;
        step(6);
        set_idle(style);
        o_cs_n = 1'b1;
        host_oe = 8'hff;
        step(2);
    endtask : par_rd
    // Clock stands low outside frames; D1 moves on the falling edge
    task ser_xfer(input logic dir, dc, input logic [7:0] wb,
        output logic [7:0] rb, output logic oe2);
        logic [7:0] sh;
        sh = wb;
        o_cs_n = 1'b0;
        o_dc = dc;
        host_oe = 8'hfb;
        drv = {4'h0, dir, 1'b0, sh[7], 1'b0};
        step(6);
        for (int i = 7; i >= 0; i--) begin
            drv[0] = 1'b1;
            step(3);
            rb[i] = o_bus[2];
            oe2 = i_dut_oe[2];
            step(3);
            sh = sh << 1;
            drv = {4'h0, dir, 1'b0, sh[7], 1'b0};
            step(6);
        end
        o_cs_n = 1'b1;
        host_oe = 8'hff;
        step(2);
    endtask : ser_xfer
endmodule : dmh_host_model
